/* File: rtl/lcsel_regs.vh */
// register map, field positions and source codes of the logic cell input source select
// Function
// R1: unimplemented bits 15, 11, 7 and 3 read as zero and ignore writes.
// R2: bits 14-12 select channel four; code 100 routes the charge time unit trigger.
// R3: code 101 drives constant high on channels four and three.
// R4: channel four 011 picks SPI serial data in, 010 comparator 3, per instance.
// R5: channel four 000 routes pin B, 001 the other cell's output.
// R6: bits 10-8 select channel three; 111 capture/compare three, 110 capture/compare two.
// R7: channel three 100 UART receive, 011 SPI data out, 010 comparator 2, per instance.
// R8: channel three 000 routes pin A, 001 the cell's own output.
// R9: channel two and one at bits 6-4, 2-0; all read/write, reset zero.
`ifndef LCSEL_REGS_VH
`define LCSEL_REGS_VH
`define LCSEL_ADDR_SEL      4'h0
`define LCSEL_SEL_MASK      16'h7777
`define LCSEL_SEL_RESET     16'h0000
`define LCSEL_CH4_LSB       12
`define LCSEL_CH3_LSB       8
`define LCSEL_CH2_LSB       4
`define LCSEL_CH1_LSB       0
`define LCSEL_SRC_CODE0     3'h0
`define LCSEL_SRC_CODE1     3'h1
`define LCSEL_SRC_CODE2     3'h2
`define LCSEL_SRC_CODE3     3'h3
`define LCSEL_SRC_CODE4     3'h4
`define LCSEL_SRC_HIGH      3'h5
`define LCSEL_SRC_CODE6     3'h6
`define LCSEL_SRC_CODE7     3'h7
`define LCSEL_RESP_OKAY     2'h0
`define LCSEL_RESP_SLVERR   2'h2
`endif

/* File: rtl/lcsel_mux8.v */
// eight-to-one source multiplexer for one data channel
module lcsel_mux8 (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire [2:0] sel,
    input  wire [7:0] src,
    output reg        chan_q
);
    // registered so the cell input is glitch free while the selector changes
    always @(posedge aclk) begin
        if (!aresetn) begin
            chan_q <= 1'b0;
        end else begin
            chan_q <= src[sel];
        end
    end
endmodule

/* File: rtl/lcsel_top.v */
// logic cell input source select with AXI4-Lite register slave
`include "lcsel_regs.vh"
module lcsel_top #(
    parameter INSTANCE = 1
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        ext_input_pin_a,
    input  wire        ext_input_pin_b,
    input  wire        peer_cell_out,
    input  wire        own_cell_out,
    input  wire        capture_compare_one_evt,
    input  wire        capture_compare_two_evt,
    input  wire        capture_compare_three_evt,
    input  wire        charge_time_unit_trig,
    input  wire        adc_done_evt,
    input  wire        uart_rx,
    input  wire        uart_tx,
    input  wire        serial_data_in_line,
    input  wire        serial_data_out_line,
    input  wire        comparator_one_out,
    input  wire        comparator_two_out,
    input  wire        comparator_three_out,
    input  wire        single_cc_four_evt,
    input  wire        single_cc_five_evt,
    input  wire        fast_osc_clk,
    input  wire        slow_osc_clk,
    input  wire        sec_osc_clk,
    input  wire        sys_cycle_clk,
    output wire        chan4_data,
    output wire        chan3_data,
    output wire        chan2_data,
    output wire        chan1_data,
    output reg  [15:0] input_source_select
);
    // INSTANCE only documents which peripheral copy is wired in; the codes match
    reg  [15:0] sel_q;
    reg  [15:0] sel_d;
    reg  [3:0]  aw_addr_q;
    reg  [31:0] w_data_q;
    reg  [3:0]  w_strb_q;
    reg         aw_have_q;
    reg         w_have_q;
    reg  [21:0] sync1_q;
    reg  [21:0] sync2_q;
    wire [21:0] raw_in;
    wire [7:0]  src4;
    wire [7:0]  src3;
    wire [7:0]  src2;
    wire [7:0]  src1;

    function is_sel_addr;
        input [3:0] a;
        begin
            is_sel_addr = (a == `LCSEL_ADDR_SEL);
        end
    endfunction

    // every outside source is asynchronous to aclk: two-flop synchronise all
    assign raw_in = {ext_input_pin_a, ext_input_pin_b, peer_cell_out, own_cell_out,
                     capture_compare_one_evt, capture_compare_two_evt, capture_compare_three_evt,
                     charge_time_unit_trig, adc_done_evt, uart_rx, uart_tx, serial_data_in_line,
                     serial_data_out_line, comparator_one_out, comparator_two_out,
                     comparator_three_out, single_cc_four_evt, single_cc_five_evt,
                     fast_osc_clk, slow_osc_clk, sec_osc_clk, sys_cycle_clk};
    always @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= 22'h000000;
            sync2_q <= 22'h000000;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    // slow clocks sampled here are only usable well below aclk/2
    assign src4 = {sync2_q[15], sync2_q[16], 1'b1, sync2_q[14],              // [R2] [R3]
                   sync2_q[10], sync2_q[6], sync2_q[19], sync2_q[20]};      // [R4] [R5]
    assign src3 = {sync2_q[15], sync2_q[16], 1'b1, sync2_q[12],              // [R6] [R3] [R7]
                   sync2_q[9], sync2_q[7], sync2_q[18], sync2_q[21]};       // [R7] [R8]
    assign src2 = {sync2_q[16], sync2_q[17], 1'b1, sync2_q[13],
                   sync2_q[11], sync2_q[8], sync2_q[19], sync2_q[20]};
    assign src1 = {sync2_q[4], sync2_q[5], 1'b1, sync2_q[3],
                   sync2_q[2], sync2_q[1], sync2_q[0], sync2_q[21]};

    lcsel_mux8 u_ch4 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sel     (sel_q[`LCSEL_CH4_LSB +: 3]),
        .src     (src4),
        .chan_q  (chan4_data)
    );
    lcsel_mux8 u_ch3 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sel     (sel_q[`LCSEL_CH3_LSB +: 3]),
        .src     (src3),
        .chan_q  (chan3_data)
    );
    lcsel_mux8 u_ch2 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sel     (sel_q[`LCSEL_CH2_LSB +: 3]),
        .src     (src2),
        .chan_q  (chan2_data)
    );
    lcsel_mux8 u_ch1 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sel     (sel_q[`LCSEL_CH1_LSB +: 3]),
        .src     (src1),
        .chan_q  (chan1_data)
    );

    // write merge with byte strobes; reserved bits forced to zero
    always @* begin
        sel_d = sel_q;
        if (w_strb_q[0]) begin
            sel_d[7:0] = w_data_q[7:0];
        end
        if (w_strb_q[1]) begin
            sel_d[15:8] = w_data_q[15:8];
        end
        sel_d = sel_d & `LCSEL_SEL_MASK;                                    // [R1] [R9]
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            sel_q               <= `LCSEL_SEL_RESET;                         // [R9]
            input_source_select <= `LCSEL_SEL_RESET;
            aw_have_q           <= 1'b0;
            w_have_q            <= 1'b0;
            aw_addr_q           <= 4'h0;
            w_data_q            <= 32'h00000000;
            w_strb_q            <= 4'h0;
            s_axi_awready       <= 1'b0;
            s_axi_wready        <= 1'b0;
            s_axi_bvalid        <= 1'b0;
            s_axi_bresp         <= `LCSEL_RESP_OKAY;
            s_axi_arready       <= 1'b0;
            s_axi_rvalid        <= 1'b0;
            s_axi_rdata         <= 32'h00000000;
            s_axi_rresp         <= `LCSEL_RESP_OKAY;
        end else begin
            input_source_select <= sel_q;
            s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q     <= 1'b1;
                aw_addr_q     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q     <= 1'b1;
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (aw_have_q && w_have_q && !s_axi_bvalid) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (is_sel_addr(aw_addr_q)) begin
                    sel_q       <= sel_d;
                    s_axi_bresp <= `LCSEL_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `LCSEL_RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                if (is_sel_addr(s_axi_araddr)) begin
                    s_axi_rdata <= {16'h0000, sel_q & `LCSEL_SEL_MASK};     // [R1]
                    s_axi_rresp <= `LCSEL_RESP_OKAY;
                end else begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `LCSEL_RESP_SLVERR;
                end
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

/* File: verification/lcsel_top_asserts.sv */
// assertion checker on the select block ports
module lcsel_top_asserts (
    input logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_bvalid, s_axi_arvalid,
    input logic        s_axi_arready, s_axi_rvalid, ext_input_pin_a, ext_input_pin_b, chan4_data, chan3_data,
    input logic [1:0]  s_axi_rresp,
    input logic [31:0] s_axi_rdata,
    input logic [15:0] input_source_select
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_unimpl_zero: assert property ((input_source_select & 16'h8888) == 16'h0000)
        else $error("reserved bit set");
    chk_reset_clear: assert property ($rose(aresetn) |-> input_source_select == 16'h0000)
        else $error("not cleared");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
        else $error("no write response");
    chk_read_answer: assert property (rd_taken |=> s_axi_rvalid)
        else $error("no read data");
    chk_read_value: assert property ($rose(s_axi_rvalid) && s_axi_rresp == 2'h0 |->
        s_axi_rdata == {16'h0000, input_source_select}) else $error("bad read data");
    chk_ch4_high: assert property ((input_source_select[14:12] == 3'h5) [*3] |-> chan4_data)
        else $error("chan4 not high");
    chk_ch4_pin_b: assert property ((input_source_select[14:12] == 3'h0 && $stable(ext_input_pin_b)) [*5]
        |-> chan4_data == ext_input_pin_b) else $error("chan4 not pin b");
    chk_ch3_pin_a: assert property ((input_source_select[10:8] == 3'h0 && $stable(ext_input_pin_a)) [*5]
        |-> chan3_data == ext_input_pin_a) else $error("chan3 not pin a");
endmodule
bind lcsel_top lcsel_top_asserts chk_u (.*);

/* File: verification/lcsel_top_tb_top.sv */
// self-checking bench for the select block
module lcsel_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, chan4_data, chan3_data, chan2_data, chan1_data;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [15:0] input_source_select;
    logic [21:0] src = 22'h0;
    int          err_count = 0, check_count = 0, cyc = 0;
    // source bit per channel (row) and code; code 5 is constant high
    logic [4:0]  tb [4][8] = '{'{1, 2, 15, 11, 7, 0, 5, 6}, '{0, 3, 14, 12, 9, 0, 5, 6},
                               '{1, 2, 13, 10, 8, 0, 4, 5}, '{0, 21, 20, 19, 18, 0, 16, 17}};
    wire  [3:0]  ch = {chan1_data, chan2_data, chan3_data, chan4_data};
    lcsel_top dut_u (.*, .ext_input_pin_a(src[0]), .ext_input_pin_b(src[1]), .peer_cell_out(src[2]),
        .own_cell_out(src[3]), .capture_compare_one_evt(src[4]), .capture_compare_two_evt(src[5]),
        .capture_compare_three_evt(src[6]), .charge_time_unit_trig(src[7]), .adc_done_evt(src[8]),
        .uart_rx(src[9]), .uart_tx(src[10]), .serial_data_in_line(src[11]), .serial_data_out_line(src[12]),
        .comparator_one_out(src[13]), .comparator_two_out(src[14]), .comparator_three_out(src[15]),
        .single_cc_four_evt(src[16]), .single_cc_five_evt(src[17]), .fast_osc_clk(src[18]),
        .slow_osc_clk(src[19]), .sec_osc_clk(src[20]), .sys_cycle_clk(src[21]));
    always #2 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) err_count = err_count + 1;
        if (cyc == 20000) test_done();
    end
    task automatic chk(input string n, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] st);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        // idle edge so the next request never reassigns in this step
        @(posedge aclk);
    endtask
    task automatic rd(input logic [3:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic t_regs;
        rd(4'h0);
        chk("reset", 32'h0, d);
        wr(4'h0, 32'hffffffff, 4'hf);
        rd(4'h0);
        chk("ones", 32'h7777, d);
        wr(4'h0, 32'h1234, 4'hf);
        wr(4'h0, 32'h5555, 4'h2);
        wr(4'h4, 32'h0, 4'hf);
        chk("bresp", 32'h2, r);
        rd(4'h8);
        chk("rresp", 32'h2, r);
        chk("rdata", 32'h0, d);
        rd(4'h0);
        chk("lane", 32'h5534, d);
        chk("mirror", 32'h5534, {16'h0, input_source_select});
        $display("regs test done");
    endtask
    task automatic t_mux;
        logic [21:0] m;
        for (int c = 0; c < 8; c++) begin
            wr(4'h0, {16'h0, {4{1'b0, c[2:0]}}}, 4'hf);
            // one source high, then all but it, so a wrong pick shows
            for (int k = 0; k < 8; k++) begin
                m = 22'h1 << tb[k % 4][c];
                src <= (k < 4) ? m : ~m;
                repeat (8) @(posedge aclk);
                for (int j = 0; j < 4; j++)
                    chk("chan", {31'h0, c == 5 || src[tb[j][c]]}, {31'h0, ch[j]});
            end
        end
        $display("mux test done");
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_regs();
        t_mux();
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_regs();
        test_done();
    end
endmodule
